// ### core/socr_core.sv
// Pixel path: polarity select, offset DAC, per-pixel gain, offset add,
// 10-bit result with conversion-done strobe and read-gated bus drive.
// Assumes all inputs are asynchronous pins; one clock, clk.
// Operation
// - Polarity bit clear samples positive-going input; set samples negative-going input.
// - Offset DAC: sign plus 4-bit magnitude, 31 steps, -25.2 to +25.2 LSB.
// - Gain per pixel is one plus code over 256 times 1.98.
// - Offset add bit set adds eight LSB after the gain stage.
// - Each pixel gives a 10-bit result; done output falls when ready.
// - Active-low read input switches the result bus between driving and released.
`timescale 1ns/10ps
module socr_core #(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Sampled sensor levels and sample strobe
    input wire logic [9:0] signal_level,
    input wire logic [9:0] reset_level,
    input wire logic sample_strobe,
    // Configuration bits
    input wire logic polarity_ccd,
    input wire logic offset_sign,
    input wire logic [3:0] offset_mag,
    input wire logic offset_add,
    // Per-pixel gain code
    input wire logic [7:0] gain_correction_bus,
    // Readout control
    input wire logic read_n,
    input wire logic result_stall,
    // Results
    output logic [9:0] pixel_result_bus_out,
    output logic pixel_result_bus_oe,
    output logic conv_done_n,
    output logic sample_ready
);
    initial
    begin
        if (BUF_DEPTH != 2)
            $error("BUF_DEPTH must be 2");
    end

    // ==================================================
    // Input synchronisers
    localparam int SYN_W = 38;
    logic [SYN_W-1:0] sync1;
    logic [SYN_W-1:0] sync2;
    logic strobe_q;
    logic pulse;
    logic [9:0] s_sig;
    logic [9:0] s_ref;
    logic s_pol;
    logic s_sign;
    logic [3:0] s_mag;
    logic s_add;
    logic [7:0] s_code;
    logic s_read_n;
    logic s_stall;

    // Two flops on every pin, third flop for strobe edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // Read pin idles high, so the bus stays released after reset
            sync1 <= {{(SYN_W-2){1'b0}}, 2'b10};
            sync2 <= {{(SYN_W-2){1'b0}}, 2'b10};
            strobe_q <= 1'b0;
        end
        else
        begin
            sync1 <= {signal_level, reset_level, sample_strobe, polarity_ccd, offset_sign,
                offset_mag, offset_add, gain_correction_bus, read_n, result_stall};
            sync2 <= sync1;
            strobe_q <= sync2[17];
        end
    end

    assign {s_sig, s_ref} = sync2[37:18];
    assign {s_pol, s_sign, s_mag, s_add, s_code, s_read_n, s_stall} = sync2[16:0];
    assign pulse = sync2[17] && !strobe_q;

    // ==================================================
    // Arithmetic stages
    logic a_valid;
    logic signed [17:0] a_v;
    logic [16:0] a_factor;
    logic a_add;
    logic b_valid;
    logic [9:0] b_word;
    logic next_a_valid;
    logic signed [17:0] next_a_v;
    logic [16:0] next_a_factor;
    logic next_a_add;
    logic next_b_valid;
    logic [9:0] next_b_word;
    logic signed [10:0] raw;
    logic signed [17:0] off_c;
    logic signed [39:0] prod;
    logic signed [39:0] lin_noadd;
    logic signed [39:0] lin;
    logic advance;
    logic fifo_full;

    // Polarity, offset and gain arithmetic
    always_comb
    begin
        advance = !b_valid || !fifo_full;
        raw = s_pol ? ($signed({1'b0, s_ref}) - $signed({1'b0, s_sig}))
                    : ($signed({1'b0, s_sig}) - $signed({1'b0, s_ref}));
        off_c = $signed({14'h0000, s_mag}) * socr_pkg::OFFSET_STEP;
        if (s_sign)
            off_c = -off_c;
        prod = $signed({{22{a_v[17]}}, a_v}) * $signed({23'h000000, a_factor});
        lin_noadd = prod / socr_pkg::GAIN_DIV;
        lin = a_add ? lin_noadd + socr_pkg::ADD_OFFSET : lin_noadd;
        next_a_valid = a_valid;
        next_a_v = a_v;
        next_a_factor = a_factor;
        next_a_add = a_add;
        next_b_valid = b_valid;
        next_b_word = b_word;
        if (advance)
        begin
            next_a_valid = pulse;
            next_a_v = $signed({{7{raw[10]}}, raw}) * socr_pkg::CENTI + off_c;
            next_a_factor = socr_pkg::GAIN_UNITY + {9'h000, s_code} * socr_pkg::GAIN_SLOPE;
            next_a_add = s_add;
            next_b_valid = a_valid;
            // Clamp to the 10-bit code range
            if (lin < 0)
                next_b_word = 10'h000;
            else if (lin > socr_pkg::RESULT_MAX)
                next_b_word = 10'h3FF;
            else
                next_b_word = lin[9:0];
        end
    end

    // Stage registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            a_valid <= 1'b0;
            a_v <= '0;
            a_factor <= '0;
            a_add <= 1'b0;
            b_valid <= 1'b0;
            b_word <= socr_pkg::RESULT_RESET;
        end
        else
        begin
            a_valid <= next_a_valid;
            a_v <= next_a_v;
            a_factor <= next_a_factor;
            a_add <= next_a_add;
            b_valid <= next_b_valid;
            b_word <= next_b_word;
        end
    end

    // ==================================================
    // Two-entry result buffer
    logic [9:0] buf_mem [BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic next_wr_ptr;
    logic next_rd_ptr;
    logic [1:0] next_count;
    logic push;
    logic pop;

    // Pointer and occupancy update
    always_comb
    begin
        fifo_full = (count == 2'h2);
        push = b_valid && !fifo_full;
        next_wr_ptr = push ? !wr_ptr : wr_ptr;
        next_rd_ptr = pop ? !rd_ptr : rd_ptr;
        next_count = count + {1'b0, push} - {1'b0, pop};
    end

    // Buffer storage and pointers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            buf_mem[0] <= socr_pkg::RESULT_RESET;
            buf_mem[1] <= socr_pkg::RESULT_RESET;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            if (push)
                buf_mem[wr_ptr] <= b_word;
        end
    end

    // ==================================================
    // Result output and done strobe
    typedef enum logic [0:0] {OUT_IDLE, OUT_LOW} socr_out_t;
    socr_out_t state;
    socr_out_t next_state;
    logic [2:0] hold;
    logic [2:0] next_hold;
    logic [9:0] next_data;
    logic next_done_n;
    logic next_oe;
    logic next_ready;

    // Present one word per done-low window
    always_comb
    begin
        next_state = state;
        next_hold = hold;
        next_data = pixel_result_bus_out;
        next_done_n = conv_done_n;
        pop = 1'b0;
        unique case (state)
            OUT_IDLE:
            begin
                if (count != 2'h0 && !s_stall)
                begin
                    pop = 1'b1;
                    next_data = buf_mem[rd_ptr];
                    next_done_n = 1'b0;
                    next_hold = 3'(socr_pkg::DONE_LOW_CYCLES - 1);
                    next_state = OUT_LOW;
                end
            end
            OUT_LOW:
            begin
                if (hold == 3'h0)
                begin
                    next_done_n = 1'b1;
                    next_state = OUT_IDLE;
                end
                else
                    next_hold = hold - 3'h1;
            end
        endcase
        next_oe = !s_read_n;
        next_ready = !(next_count == 2'h2);
    end

    // Output registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= OUT_IDLE;
            hold <= 3'h0;
            pixel_result_bus_out <= socr_pkg::RESULT_RESET;
            conv_done_n <= 1'b1;
            pixel_result_bus_oe <= 1'b0;
            sample_ready <= 1'b1;
        end
        else
        begin
            state <= next_state;
            hold <= next_hold;
            pixel_result_bus_out <= next_data;
            conv_done_n <= next_done_n;
            pixel_result_bus_oe <= next_oe;
            sample_ready <= next_ready;
        end
    end

    // ==================================================
    // Checks
    a_polarity_select: assert property (@(posedge clk) disable iff (!rstn)
        (pulse && advance && s_mag == 4'h0) |=> a_v == ($past(s_pol) ?
        ($signed({8'h00, $past(s_ref)}) - $signed({8'h00, $past(s_sig)})) * 18'sd100
        : ($signed({8'h00, $past(s_sig)}) - $signed({8'h00, $past(s_ref)})) * 18'sd100))
        else $error("sampled difference ignores polarity");
    a_offset_range: assert property (@(posedge clk) disable iff (!rstn)
        off_c <= socr_pkg::OFFSET_LIMIT && off_c >= -socr_pkg::OFFSET_LIMIT
        && (off_c % socr_pkg::OFFSET_STEP) == 0)
        else $error("offset outside step grid");
    a_gain_unity: assert property (@(posedge clk) disable iff (!rstn)
        (advance && a_valid && a_factor == socr_pkg::GAIN_UNITY && !a_add
        && a_v >= 0 && a_v <= 18'sd102300 && (a_v % 100) == 0)
        |=> b_word == $past(a_v) / 100)
        else $error("code zero is not unity gain");
    a_add_eight: assert property (@(posedge clk) disable iff (!rstn)
        (advance && a_add && lin_noadd >= 0 && lin_noadd <= 40'sd1015)
        |=> b_word == $past(lin_noadd[9:0]) + 10'h008)
        else $error("offset add not eight LSB");
    a_done_word_ready: assert property (@(posedge clk) disable iff (!rstn)
        $fell(conv_done_n) |-> $past(count) != 2'h0 ##1 !conv_done_n [*3] ##1 conv_done_n)
        else $error("done strobe without word or wrong width");
    a_word_stable_low: assert property (@(posedge clk) disable iff (!rstn)
        (!conv_done_n && $past(!conv_done_n)) |-> $stable(pixel_result_bus_out))
        else $error("result changed while done low");
    a_read_drives_bus: assert property (@(posedge clk) disable iff (!rstn)
        $fell(read_n) |-> ##3 pixel_result_bus_oe)
        else $error("bus not driven after read");
    a_read_releases_bus: assert property (@(posedge clk) disable iff (!rstn)
        $rose(read_n) |-> ##3 !pixel_result_bus_oe)
        else $error("bus not released after read");
endmodule

// ### shared/socr_pkg.sv
// Constants for the sensor offset, gain and readout core.
// Assumes sample levels arrive as 10-bit codes in conversion LSB units.
package socr_pkg;
    // ==================================================
    // Data widths
    localparam int CODE_W = 10;
    localparam int GAIN_W = 8;
    localparam int MAG_W = 4;
    // ==================================================
    // Arithmetic scale: values carried in hundredths of an LSB
    localparam logic signed [17:0] CENTI = 18'sh00064;
    localparam logic signed [17:0] OFFSET_STEP = 18'sh000A8;
    localparam logic [16:0] GAIN_UNITY = 17'h06400;
    localparam logic [16:0] GAIN_SLOPE = 17'h000C6;
    localparam logic signed [39:0] GAIN_DIV = 40'sh0000271000;
    localparam logic signed [39:0] ADD_OFFSET = 40'sh0000000008;
    localparam logic signed [39:0] RESULT_MAX = 40'sh00000003FF;
    localparam logic signed [17:0] OFFSET_LIMIT = 18'sh009D8;
    // ==================================================
    // Timing and reset values
    localparam int DONE_LOW_CYCLES = 4;
    localparam logic [9:0] RESULT_RESET = 10'h000;
endpackage

// ### bench/socr_ctrl_model.sv
// Scanner controller model: stores each result word in pixel memory.
// Assumes the bench ties read_n to conv_done_n.
`timescale 1ns/10ps
module socr_ctrl_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Device result side
    input wire logic [9:0] pixel_result_bus_out,
    input wire logic pixel_result_bus_oe,
    input wire logic conv_done_n
);
    logic [9:0] got[$];
    logic [9:0] last_seen;
    logic prev_done_n;
    int low_len;
    int bad_len;
    // Released bus shows the inverse of its value in the previous cycle
    wire logic [9:0] bus_wire = pixel_result_bus_oe ? pixel_result_bus_out : ~last_seen;
    // ==================================================
    // Capture on the done rise, measure each low window
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_done_n <= 1'b1;
            low_len <= 0;
            last_seen <= 10'h000;
        end
        else
        begin
            prev_done_n <= conv_done_n;
            last_seen <= bus_wire;
            if (conv_done_n === 1'b0)
                low_len <= low_len + 1;
            if (conv_done_n === 1'b1 && prev_done_n === 1'b0)
            begin
                got.push_back(bus_wire);
                if (low_len != socr_pkg::DONE_LOW_CYCLES)
                    bad_len <= bad_len + 1;
                low_len <= 0;
            end
        end
    end
    initial bad_len = 0;
endmodule

// ### bench/sensor_offset_cal_readout_test.sv
// Self-checking bench for the offset, gain and readout core.
// Assumes a 10 MHz clock and the controller model beside the device.
`timescale 1ns/10ps
module sensor_offset_cal_readout_test;
    logic clk = 0;
    logic rstn = 0;
    logic [9:0] signal_level = 0;
    logic [9:0] reset_level = 0;
    logic sample_strobe = 0;
    logic polarity_ccd = 0;
    logic offset_sign = 0;
    logic [3:0] offset_mag = 0;
    logic offset_add = 0;
    logic [7:0] gain_correction_bus = 0;
    logic rd_follow = 1;
    logic rd_pin = 1;
    logic result_stall = 0;
    logic [9:0] pixel_result_bus_out;
    logic pixel_result_bus_oe;
    logic conv_done_n;
    logic sample_ready;
    logic [9:0] exp_q[$];
    int fail_count = 0;
    int compares = 0;
    int n;
    int v1;
    int v2;
    int dac;
    logic cal_add;
    wire logic read_n = rd_follow ? conv_done_n : rd_pin;
    socr_core dut (.clk(clk), .rstn(rstn), .signal_level(signal_level),
        .reset_level(reset_level), .sample_strobe(sample_strobe), .polarity_ccd(polarity_ccd),
        .offset_sign(offset_sign), .offset_mag(offset_mag), .offset_add(offset_add),
        .gain_correction_bus(gain_correction_bus), .read_n(read_n),
        .result_stall(result_stall), .pixel_result_bus_out(pixel_result_bus_out),
        .pixel_result_bus_oe(pixel_result_bus_oe), .conv_done_n(conv_done_n),
        .sample_ready(sample_ready));
    socr_ctrl_model ctrl (.clk(clk), .rstn(rstn), .pixel_result_bus_out(pixel_result_bus_out),
        .pixel_result_bus_oe(pixel_result_bus_oe), .conv_done_n(conv_done_n));
    // Clock generator
    always #50 clk = ~clk;
    // ==================================================
    // Helpers
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #10;
    endtask
    task automatic check(string what, logic [9:0] e, logic [9:0] g);
        compares++;
        if (e !== g)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [9:0] expect_word(logic [9:0] s, logic [9:0] r, logic pol,
        logic sg, logic [3:0] m, logic ad, logic [7:0] c);
        longint d;
        longint v;
        d = pol ? longint'(r) - longint'(s) : longint'(s) - longint'(r);
        v = (d * 100 + (sg ? -168 : 168) * longint'(m)) * (25600 + 198 * longint'(c));
        v = v / 2560000 + (ad ? 8 : 0);
        return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
    endfunction
    task automatic fire(logic [9:0] s, logic [9:0] r, logic pol, logic sg, logic [3:0] m,
        logic ad, logic [7:0] c);
        while (pixel_result_bus_oe === 1'b1) tick(1);
        {signal_level, reset_level, polarity_ccd, offset_sign} = {s, r, pol, sg};
        {offset_mag, offset_add, gain_correction_bus} = {m, ad, c};
        exp_q.push_back(expect_word(s, r, pol, sg, m, ad, c));
        sample_strobe = 1;
        tick(3);
        sample_strobe = 0;
        tick(3);
    endtask
    task automatic drain(string name);
        for (int k = 0; k < 400 && ctrl.got.size() < exp_q.size(); k++) tick(1);
        tick(12);
        check("word count", exp_q.size(), ctrl.got.size());
        while (exp_q.size() > 0 && ctrl.got.size() > 0)
            check("pixel word", exp_q.pop_front(), ctrl.got.pop_front());
        check("done low windows", 0, ctrl.bad_len);
        exp_q.delete();
        $display("test %s done", name);
    endtask
    // One dark line of four pixels, codes resent per pixel, returns mean word
    task automatic black_line(logic sg, logic [3:0] m, logic ad, logic [7:0] c, output int avg);
        int sum;
        sum = 0;
        for (int p = 0; p < 4; p++)
            fire(10'h100, 10'h108, 0, sg, m, ad, c);
        for (int k = 0; k < 400 && ctrl.got.size() < exp_q.size(); k++) tick(1);
        foreach (ctrl.got[k])
            sum += ctrl.got[k];
        avg = sum / 4;
        drain("black line");
    endtask
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==================================================
    // Watchdog
    initial
    begin
        #3000000;
        fail_count++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        void'($urandom(90));
        tick(8);
        check("reset outputs", 10'h001, {pixel_result_bus_out[7:0], pixel_result_bus_oe,
            conv_done_n});
        check("reset ready", 10'h001, sample_ready);
        rstn = 1;
        tick(2);
        for (int i = 0; i < 8; i++)
            fire(10'h12C, 10'h064, i[0], i[1], 4'hF, i[2], i[0] ? 8'hFF : 8'h00);
        fire(10'h3FF, 10'h000, 0, 0, 4'hF, 1, 8'hFF);
        fire(10'h3FF, 10'h000, 1, 1, 4'hF, 0, 8'h00);
        drain("corners");
        for (int i = 0; i < 24; i++)
            fire($urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom);
        drain("random");
        result_stall = 1;
        n = 0;
        while (sample_ready === 1'b1 && n < 6)
        begin
            fire($urandom, $urandom, $urandom, 0, $urandom, $urandom, $urandom);
            tick(4);
            n++;
        end
        check("ready when full", 10'h000, sample_ready);
        tick(20);
        result_stall = 0;
        drain("stall");
        // Offset calibration, settings changed only between lines
        black_line(0, 4'hF, 0, 8'h00, v1);
        black_line(0, 4'hF, 0, 8'hFF, v2);
        dac = 15 + (10 * (v1 - v2)) / 32;
        if (dac > 15)
            dac = 15;
        if (dac < -15)
            dac = -15;
        cal_add = !(3 * v1 > v2);
        black_line(dac < 0, 4'((dac < 0) ? -dac : dac), cal_add, 8'h00, n);
        check("cal residual", (3 * v1 - v2) / 2 + (cal_add ? 8 : 0), n);
        rd_follow = 0;
        rd_pin = 0;
        tick(1);
        check("bus released early", 10'h000, pixel_result_bus_oe);
        tick(4);
        check("bus driven", 10'h001, pixel_result_bus_oe);
        rd_pin = 1;
        tick(5);
        check("bus released", 10'h000, pixel_result_bus_oe);
        $display("test read done");
        end_of_test();
    end
endmodule
